// >>> rtl/ssx_pkg.sv
package ssx_pkg;
    // instruction word and operand fields
    localparam int INSTR_W = 14;
    localparam int DATA_W = 8;
    localparam int FILE_AW = 7;
    localparam int FILE_DEPTH = 128;
    localparam int DEST_BIT = 7;
    localparam logic [13:0] OP_POWER_DOWN = 14'h0063;
    localparam logic [4:0] OP_LIT_SUB_TOP = 5'h1e;
    localparam logic [5:0] OP_FILE_SUB_TOP = 6'h02;

    // bus map, byte addresses
    localparam int ADDR_W = 12;
    localparam logic [11:0] OFS_INSTR = 12'h000;
    localparam logic [11:0] OFS_ACC = 12'h004;
    localparam logic [11:0] OFS_STATUS = 12'h008;
    localparam logic [11:0] OFS_CTRL = 12'h00c;
    localparam logic [11:0] OFS_WDOG = 12'h010;
    localparam logic [11:0] OFS_FILE_BASE = 12'h200;
    localparam logic [2:0] FILE_WIN_TOP = 3'h1;

    // status and control word layout
    localparam int ST_CARRY = 0;
    localparam int ST_DIGIT = 1;
    localparam int ST_ZERO = 2;
    localparam int ST_PDOWN = 3;
    localparam int ST_TOUT = 4;
    localparam int ST_SLEEP = 5;
    localparam int ST_BUSY = 6;
    localparam int CTRL_WAKE = 0;

    // reset values
    localparam logic [7:0] ACC_RST = 8'h00;
    localparam logic PDOWN_RST = 1'b1;
    localparam logic TOUT_RST = 1'b1;
    localparam logic [7:0] WDOG_CLEAR = 8'h00;
    localparam logic [7:0] WDOG_PRE_CLEAR = 8'h00;

    // axi answers
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_FETCH = 3'b010,
        ST_EXEC = 3'b100
    } ssx_state_t;
endpackage : ssx_pkg

// >>> rtl/ssx_alu_if.sv
`timescale 1ns/100ps
`default_nettype none
interface ssx_alu_if;
    logic [7:0] minuend;
    logic [7:0] subtrahend;
    logic [7:0] diff;
    logic carry;
    logic digit;
    logic zero;
    modport core (output minuend, output subtrahend, input diff, input carry, input digit, input zero);
    modport alu (input minuend, input subtrahend, output diff, output carry, output digit, output zero);
endinterface : ssx_alu_if
`default_nettype wire

// >>> rtl/ssx_sub_alu.sv
`timescale 1ns/100ps
`default_nettype none
module ssx_sub_alu (
    ssx_alu_if.alu a
);
    wire logic [8:0] full_sum;
    wire logic [4:0] low_sum;

    // two's complement: minuend + ~subtrahend + 1
    assign full_sum = {1'b0, a.minuend} + {1'b0, ~a.subtrahend} + 9'h001; // see RULE_04
    assign low_sum = {1'b0, a.minuend[3:0]} + {1'b0, ~a.subtrahend[3:0]} + 5'h01;
    assign a.diff = full_sum[7:0];
    assign a.carry = full_sum[8]; // see RULE_06
    assign a.digit = low_sum[4]; // see RULE_09
    assign a.zero = (full_sum[7:0] == 8'h00);
endmodule : ssx_sub_alu
`default_nettype wire

// >>> rtl/ssx_file_mem.sv
`timescale 1ns/100ps
`default_nettype none
module ssx_file_mem
    import ssx_pkg::*;
(
    // clock
    input wire logic sys_clk,
    // write port
    input wire logic wr_en,
    input wire logic [6:0] wr_addr,
    input wire logic [7:0] wr_data,
    // read port
    input wire logic [6:0] rd_addr,
    output logic [7:0] rd_data
);
    logic [7:0] mem [FILE_DEPTH];

    always_ff @(posedge sys_clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        rd_data <= mem[rd_addr];
    end
endmodule : ssx_file_mem
`default_nettype wire

// >>> rtl/ssx_core.sv
// Summary of operation
// RULE_01: power-down opcode clears the power-down flag and sets the time-out flag.
// RULE_02: power-down also clears the watchdog counter and its prescaler.
// RULE_03: after power-down the core sleeps; no instruction executes until wake-up.
// RULE_04: literal subtract computes literal minus accumulator in two's complement.
// RULE_05: literal subtract writes the accumulator and updates carry, digit carry, zero.
// RULE_06: carry is an inverted borrow: one when difference is zero or positive.
// RULE_07: file subtract computes addressed register minus accumulator, updating all three flags.
// RULE_08: destination bit zero writes the accumulator, one writes the file register.
// RULE_09: digit carry is set unless a borrow leaves the low nibble.
//
// The AXI4-Lite slave port and the register addresses were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module ssx_core
    import ssx_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic arst_n,
    // axi write address
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    // axi write data
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    // axi write response
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    output logic [1:0] s_axi_bresp,
    // axi read address
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    // axi read data
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    // core state
    output logic sleep_state,
    output logic osc_run
);
    function automatic logic is_power_down(input logic [13:0] op);
        return op == OP_POWER_DOWN;
    endfunction : is_power_down

    function automatic logic is_lit_sub(input logic [13:0] op);
        return op[13:9] == OP_LIT_SUB_TOP;
    endfunction : is_lit_sub

    function automatic logic is_file_sub(input logic [13:0] op);
        return op[13:8] == OP_FILE_SUB_TOP;
    endfunction : is_file_sub

    function automatic logic in_file_win(input logic [11:0] adr);
        return adr[11:9] == FILE_WIN_TOP;
    endfunction : in_file_win

    function automatic logic reg_at(input logic [11:0] adr, input logic [11:0] ofs);
        return adr[11:2] == ofs[11:2];
    endfunction : reg_at

    ssx_state_t state_q;
    ssx_state_t state_d;
    logic [13:0] instr_q;
    logic [7:0] acc_q;
    logic carry_q;
    logic digit_q;
    logic zero_q;
    logic pdown_q;
    logic tout_q;
    logic sleep_q;
    logic [7:0] wdog_q;
    logic [7:0] wdog_pre_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0] rresp_q;
    logic rd_pend_q;

    ssx_alu_if alu_bus ();
    wire logic [7:0] mem_rd_data;
    wire logic [6:0] mem_rd_addr;
    wire logic mem_wr_en;
    wire logic [6:0] mem_wr_addr;
    wire logic [7:0] mem_wr_data;

    // bus handshakes and decode
    wire logic idle = (state_q == ST_IDLE);
    wire logic wr_go = s_axi_awvalid && s_axi_wvalid && s_axi_awready;
    wire logic rd_go = s_axi_arvalid && s_axi_arready;
    wire logic strobe_lo = s_axi_wstrb[0];
    wire logic wr_instr = wr_go && reg_at(s_axi_awaddr, OFS_INSTR) && s_axi_wstrb[1] && strobe_lo;
    wire logic wr_acc = wr_go && reg_at(s_axi_awaddr, OFS_ACC) && strobe_lo;
    wire logic wr_status = wr_go && reg_at(s_axi_awaddr, OFS_STATUS) && strobe_lo;
    wire logic wr_ctrl = wr_go && reg_at(s_axi_awaddr, OFS_CTRL) && strobe_lo;
    wire logic wr_file = wr_go && in_file_win(s_axi_awaddr) && strobe_lo;
    wire logic wr_hit = reg_at(s_axi_awaddr, OFS_INSTR) || reg_at(s_axi_awaddr, OFS_ACC)
        || reg_at(s_axi_awaddr, OFS_STATUS) || reg_at(s_axi_awaddr, OFS_CTRL)
        || in_file_win(s_axi_awaddr);
    wire logic rd_file = rd_go && in_file_win(s_axi_araddr);
    wire logic wake_req = wr_ctrl && s_axi_wdata[CTRL_WAKE];

    // instructions are taken only while idle and awake
    wire logic issue = wr_instr && !sleep_q; // see RULE_03
    wire logic exec = (state_q == ST_EXEC);
    wire logic ex_pdown = exec && is_power_down(instr_q);
    wire logic ex_lit = exec && is_lit_sub(instr_q);
    wire logic ex_file = exec && is_file_sub(instr_q);
    wire logic dest_file = instr_q[DEST_BIT];

    // both write channels are taken together, and never while an instruction runs
    assign s_axi_awready = idle && !bvalid_q && s_axi_wvalid;
    assign s_axi_wready = idle && !bvalid_q && s_axi_awvalid;
    // a pending file read holds arready low until its word is registered
    assign s_axi_arready = idle && !rvalid_q && !rd_pend_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;
    assign sleep_state = sleep_q;
    assign osc_run = !sleep_q; // see RULE_03

    // subtract datapath: literal or file operand minus accumulator
    assign alu_bus.minuend = is_file_sub(instr_q) ? mem_rd_data : instr_q[7:0]; // see RULE_04, RULE_07
    assign alu_bus.subtrahend = acc_q;

    ssx_sub_alu u_alu (
        .a(alu_bus.alu)
    );

    // file port: core owns it outside idle
    assign mem_rd_addr = idle ? s_axi_araddr[8:2] : instr_q[6:0];
    assign mem_wr_en = (ex_file && dest_file) || wr_file; // see RULE_08
    assign mem_wr_addr = idle ? s_axi_awaddr[8:2] : instr_q[6:0];
    assign mem_wr_data = idle ? s_axi_wdata[7:0] : alu_bus.diff;

    ssx_file_mem u_mem (
        .sys_clk(sys_clk),
        .wr_en(mem_wr_en),
        .wr_addr(mem_wr_addr),
        .wr_data(mem_wr_data),
        .rd_addr(mem_rd_addr),
        .rd_data(mem_rd_data)
    );

    // sequencer: file operands need one read cycle
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            ST_IDLE: begin
                if (issue) begin
                    state_d = is_file_sub(s_axi_wdata[13:0]) ? ST_FETCH : ST_EXEC;
                end
            end
            ST_FETCH: begin
                state_d = ST_EXEC;
            end
            ST_EXEC: begin
                state_d = ST_IDLE;
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_q <= ST_IDLE;
            instr_q <= 14'h0000;
        end else begin
            state_q <= state_d;
            if (issue) begin
                instr_q <= s_axi_wdata[13:0];
            end
        end
    end

    // accumulator
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            acc_q <= ACC_RST;
        end else if (ex_lit || (ex_file && !dest_file)) begin
            acc_q <= alu_bus.diff; // see RULE_05, RULE_08
        end else if (wr_acc) begin
            acc_q <= s_axi_wdata[7:0];
        end
    end

    // arithmetic flags
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            carry_q <= 1'b0;
            digit_q <= 1'b0;
            zero_q <= 1'b0;
        end else if (ex_lit || ex_file) begin
            carry_q <= alu_bus.carry; // see RULE_05, RULE_06, RULE_07
            digit_q <= alu_bus.digit; // see RULE_09
            zero_q <= alu_bus.zero;
        end else if (wr_status) begin
            carry_q <= s_axi_wdata[ST_CARRY];
            digit_q <= s_axi_wdata[ST_DIGIT];
            zero_q <= s_axi_wdata[ST_ZERO];
        end
    end

    // power flags and sleep
    // a wake clears only sleep; both power flags keep what power-down left
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            pdown_q <= PDOWN_RST;
            tout_q <= TOUT_RST;
            sleep_q <= 1'b0;
        end else if (ex_pdown) begin
            pdown_q <= 1'b0; // see RULE_01
            tout_q <= 1'b1; // see RULE_01
            sleep_q <= 1'b1; // see RULE_03
        end else if (wake_req) begin
            sleep_q <= 1'b0;
        end
    end

    // watchdog counter and prescaler stop with the oscillator
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            wdog_pre_q <= WDOG_PRE_CLEAR;
            wdog_q <= WDOG_CLEAR;
        end else if (ex_pdown) begin
            wdog_pre_q <= WDOG_PRE_CLEAR; // see RULE_02
            wdog_q <= WDOG_CLEAR; // see RULE_02
        end else if (!sleep_q) begin
            wdog_pre_q <= wdog_pre_q + 8'h01;
            if (wdog_pre_q == 8'hff) begin
                wdog_q <= wdog_q + 8'h01;
            end
        end
    end

    // write response
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
        end else if (wr_go) begin
            bvalid_q <= 1'b1;
            bresp_q <= wr_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_q <= 1'b0;
        end
    end

    // read data: registers at once, file window one cycle later
    logic [31:0] status_word;
    always_comb begin
        status_word = 32'h00000000;
        status_word[ST_CARRY] = carry_q;
        status_word[ST_DIGIT] = digit_q;
        status_word[ST_ZERO] = zero_q;
        status_word[ST_PDOWN] = pdown_q;
        status_word[ST_TOUT] = tout_q;
        status_word[ST_SLEEP] = sleep_q;
        status_word[ST_BUSY] = !idle;
    end
    wire logic rd_instr = reg_at(s_axi_araddr, OFS_INSTR);
    wire logic rd_acc = reg_at(s_axi_araddr, OFS_ACC);
    wire logic rd_status = reg_at(s_axi_araddr, OFS_STATUS);
    wire logic rd_ctrl = reg_at(s_axi_araddr, OFS_CTRL);
    wire logic rd_wdog = reg_at(s_axi_araddr, OFS_WDOG);
    wire logic rd_hit = rd_instr || rd_acc || rd_status || rd_ctrl || rd_wdog;
    wire logic [31:0] reg_word = rd_instr ? {18'h00000, instr_q}
        : rd_acc ? {24'h000000, acc_q}
        : rd_status ? status_word
        : rd_wdog ? {24'h000000, wdog_q}
        : 32'h00000000;

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            rvalid_q <= 1'b0;
            rdata_q <= 32'h00000000;
            rresp_q <= RESP_OKAY;
            rd_pend_q <= 1'b0;
        end else if (rd_file) begin
            rd_pend_q <= 1'b1;
        end else if (rd_pend_q) begin
            rd_pend_q <= 1'b0;
            rvalid_q <= 1'b1;
            rdata_q <= {24'h000000, mem_rd_data};
            rresp_q <= RESP_OKAY;
        end else if (rd_go) begin
            rvalid_q <= 1'b1;
            rdata_q <= reg_word;
            rresp_q <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end
endmodule : ssx_core
`default_nettype wire

// >>> sim/ssx_core_checker.sv
`timescale 1ns/100ps
`default_nettype none
module ssx_core_checker (
    // clock and reset
    input wire logic sys_clk,
    input wire logic arst_n,
    // bus
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    // core
    input wire logic sleep_state,
    input wire logic osc_run
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!arst_n);
    wire logic wr_take = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    sequence s_take_wr;
        wr_take;
    endsequence
    sequence s_hold_b;
        s_axi_bvalid && !s_axi_bready;
    endsequence
    a_osc_follows: assert property (osc_run == !sleep_state)
        else $error("osc_run is not the inverse of sleep_state");
    a_sleep_cause: assert property ($rose(sleep_state) |-> $past(wr_take, 2))
        else $error("sleep entered without a write two cycles before");
    a_wake_cause: assert property ($fell(sleep_state) |-> $past(wr_take) || $past(wr_take, 2))
        else $error("sleep left without a write");
    a_write_answer: assert property (s_take_wr |=> s_axi_bvalid && !s_axi_awready)
        else $error("write response missing one cycle after accept");
    a_wr_refuse: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while response pending");
    a_b_hold: assert property (s_hold_b |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped before bready");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> !s_axi_arready ##[0:1] s_axi_rvalid)
        else $error("read data not within two cycles");
    a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data changed before rready");
endmodule : ssx_core_checker
bind ssx_core ssx_core_checker checker_inst (.*);
`default_nettype wire

// >>> sim/tb_sleep_and_subtract_execute.sv
`timescale 1ns/100ps
`default_nettype none
module tb_sleep_and_subtract_execute
    import ssx_pkg::*;
;
    logic sys_clk = 1'b0;
    logic arst_n = 1'b0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [11:0] awaddr = 12'h000, araddr = 12'h000;
    logic [31:0] wdata = 32'h0, rdata;
    logic awready, wready, bvalid, arready, rvalid, slp, osc;
    logic [1:0] bresp, rresp;
    logic [3:0] hs;
    int bad_count = 0;
    int total_checks = 0;
    assign hs = {rvalid, arready, bvalid, awready};
    ssx_core ssx_core_inst (.sys_clk(sys_clk), .arst_n(arst_n),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .sleep_state(slp), .osc_run(osc));
    initial begin
        forever #20 sys_clk = ~sys_clk;
    end
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : print_verdict
    // waits for one handshake flag, bounded
    task automatic waitfor(input int i);
        int n;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (hs[i] !== 1'b1 && n < 500);
        if (hs[i] !== 1'b1) begin
            bad_count++;
            print_verdict();
        end
    endtask : waitfor
    // a random lag on bready, or on rready of a register read, lets the answer stand unaccepted for a cycle
    task automatic axw(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
        logic lag;
        lag = 1'($urandom);
        @(posedge sys_clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= !lag;
        waitfor(0);
        awvalid <= 1'b0;
        wvalid <= 1'b0;
        if (lag) begin
            @(posedge sys_clk);
            bready <= 1'b1;
        end
        waitfor(1);
        bready <= 1'b0;
        chk("bresp", 32'(bresp), 32'(er));
    endtask : axw
    task automatic axr(input logic [11:0] a, input logic [1:0] er, output logic [31:0] d);
        logic lag;
        lag = 1'($urandom);
        @(posedge sys_clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= !lag;
        waitfor(2);
        arvalid <= 1'b0;
        if (lag) begin
            @(posedge sys_clk);
            rready <= 1'b1;
        end
        waitfor(3);
        rready <= 1'b0;
        d = rdata;
        chk("rresp", 32'(rresp), 32'(er));
    endtask : axr
    task automatic rchk(input string nm, input logic [11:0] a, input logic [31:0] e);
        logic [31:0] d;
        axr(a, RESP_OKAY, d);
        chk(nm, d, e);
    endtask : rchk
    // {zero, digit carry, carry, difference} of x minus y
    function automatic logic [10:0] sub(input logic [7:0] x, input logic [7:0] y);
        logic [7:0] r;
        r = x - y;
        return {r == 8'h00, x[3:0] >= y[3:0], x >= y, r};
    endfunction : sub
    initial begin
        logic [15:0] lc [5];
        logic [31:0] d;
        logic [10:0] e;
        logic [7:0] a, k, w;
        logic [6:0] f;
        logic [11:0] fa;
        logic dst;
        int s;
        lc = '{16'h0201, 16'h0202, 16'h0203, 16'h00ff, 16'h1001};
        s = $urandom(8203);
        repeat (4) @(posedge sys_clk);
        arst_n <= 1'b1;
        rchk("status_rst", OFS_STATUS, 32'h18);
        rchk("acc_rst", OFS_ACC, 32'h0);
        axw(OFS_STATUS, 32'h7, RESP_OKAY);
        rchk("status_wr", OFS_STATUS, 32'h1f);
        for (int i = 0; i < 30; i++) begin
            {k, a} = i < 5 ? lc[i] : 16'($urandom);
            e = sub(k, a);
            axw(OFS_ACC, {24'h0, a}, RESP_OKAY);
            axw(OFS_INSTR, {18'h0, OP_LIT_SUB_TOP, 1'(i), k}, RESP_OKAY);
            rchk("lit_acc", OFS_ACC, {24'h0, e[7:0]});
            rchk("lit_flags", OFS_STATUS, {27'h0, 2'b11, e[10:8]});
        end
        for (int i = 0; i < 30; i++) begin
            {k, a} = i < 5 ? lc[i] : 16'($urandom);
            f = 7'($urandom);
            dst = i[0];
            fa = OFS_FILE_BASE + {3'h0, f, 2'b00};
            e = sub(k, a);
            w = dst ? a : e[7:0];
            axw(fa, {24'h0, k}, RESP_OKAY);
            axw(OFS_ACC, {24'h0, a}, RESP_OKAY);
            axw(OFS_INSTR, {18'h0, OP_FILE_SUB_TOP, dst, f}, RESP_OKAY);
            rchk("file_acc", OFS_ACC, {24'h0, w});
            rchk("file_reg", fa, {24'h0, dst ? e[7:0] : k});
            rchk("file_flags", OFS_STATUS, {27'h0, 2'b11, e[10:8]});
        end
        axw(12'h100, 32'h0, RESP_SLVERR);
        axr(12'h100, RESP_SLVERR, d);
        repeat (600) @(posedge sys_clk);
        axr(OFS_WDOG, RESP_OKAY, d);
        chk("wdog_run", 32'(d != 32'h0), 32'h1);
        axw(OFS_INSTR, {18'h0, OP_POWER_DOWN}, RESP_OKAY);
        rchk("sleep_status", OFS_STATUS, {26'h0, 3'b110, e[10:8]});
        rchk("wdog_clr", OFS_WDOG, 32'h0);
        chk("pins", {30'h0, slp, osc}, 32'h2);
        axw(OFS_INSTR, {18'h0, OP_LIT_SUB_TOP, 1'b0, 8'h55}, RESP_OKAY);
        rchk("asleep_acc", OFS_ACC, {24'h0, w});
        rchk("asleep_instr", OFS_INSTR, {18'h0, OP_POWER_DOWN});
        axw(OFS_CTRL, 32'h1, RESP_OKAY);
        rchk("woken", OFS_STATUS, {26'h0, 3'b010, e[10:8]});
        chk("pins_awake", {30'h0, slp, osc}, 32'h1);
        axw(OFS_INSTR, 32'h8, RESP_OKAY);
        rchk("other_acc", OFS_ACC, {24'h0, w});
        rchk("other_status", OFS_STATUS, {26'h0, 3'b010, e[10:8]});
        rchk("ctrl_rd", OFS_CTRL, 32'h0);
        print_verdict();
    end
endmodule : tb_sleep_and_subtract_execute
`default_nettype wire
